// file: design/tsi_pkg.sv
// Constants, types and the PEC function shared by the temperature sensor serial slave.
package tsi_pkg;

    localparam logic [6:0]  DEF_SLAVE_ADDR = 7'h48;
    localparam logic [7:0]  PTR_TEMP       = 8'h00;
    localparam logic [7:0]  PTR_CFG        = 8'h01;
    localparam logic [7:0]  PTR_HYST       = 8'h02;
    localparam logic [7:0]  PTR_TOS        = 8'h03;
    localparam logic [15:0] TEMP_RST       = 16'h0000;
    localparam logic [15:0] CFG_RST        = 16'h0040;
    localparam logic [15:0] HYST_RST       = 16'h4b00;
    localparam logic [15:0] TOS_RST        = 16'h5000;
    localparam int          CFG_PEC_BIT    = 3;
    localparam int          CFG_TMO_BIT    = 4;
    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam int          SYS_CLK_HZ     = 50_000_000;
    localparam int          TIMEOUT_MS     = 30;
    localparam int          TIMEOUT_CYC    = (SYS_CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int          TMO_W          = 21;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100,
        ST_WAIT = 3'b101
    } tsi_state_t;

    typedef enum logic [1:0] {
        BY_ADDR = 2'b00,
        BY_PTR  = 2'b01,
        BY_DATA = 2'b10
    } tsi_byte_t;

    // One byte of the SMBus CRC-8, most significant bit first.
    function automatic logic [7:0] tsi_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

// file: design/tsi_line_if.sv
// Synchronised bus line events passed from the line conditioner to the slave engine.
`timescale 1ns/1ns
interface tsi_line_if;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport src (output scl_lvl, output sda_lvl, output scl_rise, output scl_fall,
                 output start, output stop);
    modport snk (input scl_lvl, input sda_lvl, input scl_rise, input scl_fall,
                 input start, input stop);
endinterface

// file: design/tsi_line_sync.sv
// Two-stage synchronisers for the bus lines plus edge, START and STOP detection.
`timescale 1ns/1ns
module tsi_line_sync (
    input  wire logic sys_clk, // System clock.
    input  wire logic rst,     // Synchronous reset, active high.
    input  wire logic scl_i,   // Bus clock pin level.
    input  wire logic sda_i,   // Bus data pin level.
    tsi_line_if.src   ln       // Conditioned line events.
);
    logic [2:0] scl_reg;
    logic [2:0] sda_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_reg <= 3'h7;
            sda_reg <= 3'h7;
        end else begin
            scl_reg <= {scl_reg[1:0], scl_i};
            sda_reg <= {sda_reg[1:0], sda_i};
        end
    end

    // Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone.
    assign ln.scl_lvl  = scl_reg[1];
    assign ln.sda_lvl  = sda_reg[1];
    assign ln.scl_rise = scl_reg[1] & ~scl_reg[2];
    assign ln.scl_fall = ~scl_reg[1] & scl_reg[2];
    assign ln.start    = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
    assign ln.stop     = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];
endmodule

// file: design/tsi_slave.sv
// Two-wire serial slave of the temperature sensor with PEC, read freeze and bus timeout.
`timescale 1ns/1ns
module tsi_slave
    import tsi_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR  = tsi_pkg::DEF_SLAVE_ADDR,
    parameter int         TMO_CYCLES  = tsi_pkg::TIMEOUT_CYC
) (
    input  wire logic        sys_clk,    // System clock, 50 MHz.
    input  wire logic        rst,        // Synchronous reset, active high.
    input  wire logic        scl_i,      // Bus clock pin.
    input  wire logic        sda_i,      // Bus data pin level.
    output logic             sda_o,      // Bus data drive value, always low.
    output logic             sda_oe,     // High while pulling the data line low.
    input  wire logic        meas_valid, // One-cycle strobe of a new measurement.
    input  wire logic [15:0] meas_data,  // New measurement word.
    output logic [15:0]      temp_o,     // Temperature register.
    output logic [15:0]      cfg_o,      // Configuration register.
    output logic [15:0]      hyst_o,     // Hysteresis threshold register.
    output logic [15:0]      tos_o       // Over-temperature threshold register.
);
    import tsi_pkg::*;

    tsi_line_if ln ();

    tsi_line_sync u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .ln      (ln.src)
    );

    tsi_state_t       state_reg,   state_next;
    tsi_byte_t        kind_reg,    kind_next;
    logic [3:0]       bit_reg,     bit_next;
    logic [7:0]       sh_reg,      sh_next;
    logic             rw_reg,      rw_next;
    logic [7:0]       ptr_reg,     ptr_next;
    logic [1:0]       wph_reg,     wph_next;
    logic [1:0]       rph_reg,     rph_next;
    logic [7:0]       hi_reg,      hi_next;
    logic [7:0]       lo_reg,      lo_next;
    logic [7:0]       crc_reg,     crc_next;
    logic             txn_reg,     txn_next;
    logic [15:0]      pend_reg,    pend_next;
    logic             pok_reg,     pok_next;
    logic             pbad_reg,    pbad_next;
    logic [15:0]      rdw_reg,     rdw_next;
    logic             frz_reg,     frz_next;
    logic             mpend_reg,   mpend_next;
    logic [15:0]      mword_reg,   mword_next;
    logic [TMO_W-1:0] tmo_reg,     tmo_next;
    logic             oe_reg,      oe_next;
    logic [15:0]      temp_reg,    temp_next;
    logic [15:0]      cfg_reg,     cfg_next;
    logic [15:0]      hyst_reg,    hyst_next;
    logic [15:0]      tos_reg,     tos_next;
    logic             do_wr;
    logic [15:0]      wr_word;
    logic             load_tx;

    wire        pec_en    = cfg_reg[CFG_PEC_BIT];
    wire        tmo_en    = ~cfg_reg[CFG_TMO_BIT];
    wire        tmo_hit   = tmo_en && (tmo_reg == TMO_W'(TMO_CYCLES - 1));
    wire        byte_done = ln.scl_fall && (bit_reg == BITS_PER_BYTE);
    wire        addr_hit  = (sh_reg[7:1] == SLAVE_ADDR);
    wire [7:0]  crc_rx    = tsi_crc8(crc_reg, sh_reg);
    wire [15:0] sel_word  = (ptr_reg == PTR_TEMP) ? temp_reg :
                            (ptr_reg == PTR_CFG)  ? cfg_reg  :
                            (ptr_reg == PTR_HYST) ? hyst_reg :
                            (ptr_reg == PTR_TOS)  ? tos_reg  : 16'h0000;
    wire [7:0]  tx_byte   = (rph_reg == 2'h0) ? rdw_reg[15:8] :
                            (rph_reg == 2'h1) ? rdw_reg[7:0]  : crc_reg;
    // PEC writes are kept only when every group checked and the last group closed.
    wire        pec_commit = pec_en && pok_reg && !pbad_reg && (wph_reg == 2'h0)
                             && (state_reg != ST_WAIT);

    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        rw_next    = rw_reg;
        ptr_next   = ptr_reg;
        wph_next   = wph_reg;
        rph_next   = rph_reg;
        hi_next    = hi_reg;
        lo_next    = lo_reg;
        crc_next   = crc_reg;
        txn_next   = txn_reg;
        pend_next  = pend_reg;
        pok_next   = pok_reg;
        pbad_next  = pbad_reg;
        rdw_next   = rdw_reg;
        frz_next   = frz_reg;
        oe_next    = oe_reg;
        do_wr      = 1'b0;
        wr_word    = {hi_reg, lo_reg};
        load_tx    = 1'b0;
        if (tmo_hit) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
            txn_next   = 1'b0;
            frz_next   = 1'b0;
            // A later STOP must not commit a group checked before the timeout.
            pok_next   = 1'b0;
        end else if (ln.start) begin
            state_next = ST_RX;
            kind_next  = BY_ADDR;
            bit_next   = 4'h0;
            oe_next    = 1'b0;
            frz_next   = 1'b0;
            wph_next   = 2'h0;
            pok_next   = 1'b0;
            pbad_next  = 1'b0;
            txn_next   = 1'b1;
            if (!txn_reg) begin
                crc_next = 8'h00;
            end
        end else if (ln.stop) begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
            txn_next   = 1'b0;
            frz_next   = 1'b0;
            if (pec_commit) begin
                do_wr   = 1'b1;
                wr_word = pend_reg;
            end
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (ln.scl_rise) begin
                        sh_next  = {sh_reg[6:0], ln.sda_lvl};
                        bit_next = bit_reg + 4'h1;
                    end else if (byte_done) begin
                        bit_next   = 4'h0;
                        crc_next   = crc_rx;
                        state_next = ST_ACK;
                        oe_next    = 1'b1;
                        case (kind_reg)
                            BY_ADDR: begin
                                rw_next  = sh_reg[0];
                                rph_next = 2'h0;
                                rdw_next = sel_word;
                                if (!addr_hit) begin
                                    state_next = ST_WAIT;
                                    oe_next    = 1'b0;
                                end else if (sh_reg[0] && ptr_reg == PTR_TEMP) begin
                                    frz_next = 1'b1;
                                end
                                if (!sh_reg[0]) begin
                                    kind_next = BY_PTR;
                                end
                            end
                            BY_PTR: begin
                                ptr_next  = sh_reg;
                                kind_next = BY_DATA;
                            end
                            default: begin
                                if (wph_reg == 2'h0) begin
                                    hi_next  = sh_reg;
                                    wph_next = 2'h1;
                                end else if (wph_reg == 2'h1) begin
                                    lo_next  = sh_reg;
                                    wph_next = pec_en ? 2'h2 : 2'h0;
                                    if (!pec_en) begin
                                        do_wr   = 1'b1;
                                        wr_word = {hi_reg, sh_reg};
                                    end
                                end else begin
                                    wph_next = 2'h0;
                                    if (sh_reg == crc_reg) begin
                                        pend_next = {hi_reg, lo_reg};
                                        pok_next  = 1'b1;
                                    end else begin
                                        pbad_next = 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (ln.scl_fall) begin
                        if (rw_reg) begin
                            load_tx = 1'b1;
                        end else begin
                            state_next = ST_RX;
                            oe_next    = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (ln.scl_fall) begin
                        if (bit_reg == 4'h7) begin
                            state_next = ST_RACK;
                            oe_next    = 1'b0;
                        end else begin
                            sh_next  = {sh_reg[6:0], 1'b0};
                            oe_next  = ~sh_reg[6];
                            bit_next = bit_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (ln.scl_rise && ln.sda_lvl) begin
                        state_next = ST_WAIT;
                        frz_next   = 1'b0;
                    end else if (ln.scl_fall) begin
                        load_tx = 1'b1;
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
            if (load_tx) begin
                state_next = ST_TX;
                sh_next    = tx_byte;
                oe_next    = ~tx_byte[7];
                bit_next   = 4'h0;
                crc_next   = tsi_crc8(crc_reg, tx_byte);
                rph_next   = (rph_reg == 2'h1 && pec_en) ? 2'h2 : (rph_reg == 2'h0) ? 2'h1 : 2'h0;
            end
        end
    end

    always_comb begin
        cfg_next   = cfg_reg;
        hyst_next  = hyst_reg;
        tos_next   = tos_reg;
        temp_next  = temp_reg;
        mword_next = mword_reg;
        mpend_next = mpend_reg;
        if (do_wr && ptr_reg == PTR_CFG) begin
            cfg_next = wr_word;
        end
        if (do_wr && ptr_reg == PTR_HYST) begin
            hyst_next = wr_word;
        end
        if (do_wr && ptr_reg == PTR_TOS) begin
            tos_next = wr_word;
        end
        if (mpend_reg && !frz_reg) begin
            temp_next  = mword_reg;
            mpend_next = 1'b0;
        end
        if (meas_valid) begin
            mword_next = meas_data;
            mpend_next = 1'b1;
        end
        if (ln.scl_lvl || !tmo_en) begin
            tmo_next = '0;
        end else if (tmo_reg == TMO_W'(TMO_CYCLES)) begin
            tmo_next = tmo_reg;
        end else begin
            tmo_next = tmo_reg + TMO_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            kind_reg  <= BY_ADDR;
            bit_reg   <= 4'h0;
            sh_reg    <= 8'h00;
            rw_reg    <= 1'b0;
            ptr_reg   <= PTR_TEMP;
            wph_reg   <= 2'h0;
            rph_reg   <= 2'h0;
            hi_reg    <= 8'h00;
            lo_reg    <= 8'h00;
            crc_reg   <= 8'h00;
            txn_reg   <= 1'b0;
            pend_reg  <= 16'h0000;
            pok_reg   <= 1'b0;
            pbad_reg  <= 1'b0;
            rdw_reg   <= 16'h0000;
            frz_reg   <= 1'b0;
            oe_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            bit_reg   <= bit_next;
            sh_reg    <= sh_next;
            rw_reg    <= rw_next;
            ptr_reg   <= ptr_next;
            wph_reg   <= wph_next;
            rph_reg   <= rph_next;
            hi_reg    <= hi_next;
            lo_reg    <= lo_next;
            crc_reg   <= crc_next;
            txn_reg   <= txn_next;
            pend_reg  <= pend_next;
            pok_reg   <= pok_next;
            pbad_reg  <= pbad_next;
            rdw_reg   <= rdw_next;
            frz_reg   <= frz_next;
            oe_reg    <= oe_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            temp_reg  <= TEMP_RST;
            cfg_reg   <= CFG_RST;
            hyst_reg  <= HYST_RST;
            tos_reg   <= TOS_RST;
            mword_reg <= TEMP_RST;
            mpend_reg <= 1'b0;
            tmo_reg   <= '0;
        end else begin
            temp_reg  <= temp_next;
            cfg_reg   <= cfg_next;
            hyst_reg  <= hyst_next;
            tos_reg   <= tos_next;
            mword_reg <= mword_next;
            mpend_reg <= mpend_next;
            tmo_reg   <= tmo_next;
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = oe_reg;
    assign temp_o = temp_reg;
    assign cfg_o  = cfg_reg;
    assign hyst_o = hyst_reg;
    assign tos_o  = tos_reg;
endmodule

// file: test/tsi_bus_master.sv
// Behavioural bus master that drives the sensor serial slave.
`timescale 1ns/1ns
module tsi_bus_master (
    input  wire logic sys_clk, // Bench clock.
    input  wire logic sda,     // Resolved data line.
    output logic      scl,     // Bus clock.
    output logic      sda_lo   // High while pulling data low.
);
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic start();
        tick(1);
        sda_lo = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_lo = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic bit_out(input logic b);
        tick(1);
        sda_lo = !b;
        tick(4);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic bit_in(input int lowx, output logic b);
        tick(1);
        sda_lo = 1'b0;
        tick(4 + lowx);
        scl = 1'b1;
        tick(2);
        b = sda;
        tick(2);
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, input int lowx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(lowx, b);
        ack = !b;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(0, d[i]);
        bit_out(!ack);
    endtask
    task automatic stop();
        tick(1);
        sda_lo = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_lo = 1'b0;
        tick(8);
    endtask
endmodule

// file: test/tsi_slave_sva.sv
// Port assertions of the sensor serial slave.
`timescale 1ns/1ns
module tsi_slave_sva
    import tsi_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = tsi_pkg::DEF_SLAVE_ADDR,
    parameter int         TMO_CYCLES = tsi_pkg::TIMEOUT_CYC
) (
    input wire logic        sys_clk,    // Clock.
    input wire logic        rst,        // Reset.
    input wire logic        scl_i,      // Bus clock.
    input wire logic        sda_i,      // Bus data.
    input wire logic        sda_o,      // Drive value.
    input wire logic        sda_oe,     // Drive enable.
    input wire logic        meas_valid, // Measurement strobe.
    input wire logic [15:0] meas_data,  // Measurement.
    input wire logic [15:0] temp_o,     // Temperature.
    input wire logic [15:0] cfg_o,      // Configuration.
    input wire logic [15:0] hyst_o,     // Hysteresis.
    input wire logic [15:0] tos_o       // Over-temperature.
);
    int          low_cnt;
    int          idle_cnt;
    logic [15:0] lm0;
    logic [15:0] lm1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk) begin
        low_cnt  <= (rst || scl_i) ? 0 : low_cnt + 1;
        idle_cnt <= (rst || !(scl_i && sda_i)) ? 0 : idle_cnt + 1;
    end
    // The last two words offered, since a taken word lands two edges late.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lm0 <= TEMP_RST;
            lm1 <= TEMP_RST;
        end else if (meas_valid) begin
            lm0 <= meas_data;
            lm1 <= lm0;
        end
    end
    a_reset_state: assert property (disable iff (1'b0) rst |=> !sda_oe && temp_o == TEMP_RST
        && cfg_o == CFG_RST && hyst_o == HYST_RST && tos_o == TOS_RST) else $error("Bad reset.");
    a_drive_low: assert property (sda_o == 1'b0) else $error("Data drive not low.");
    a_temp_take: assert property (
        idle_cnt > 8 && meas_valid |-> ##2 temp_o == $past(meas_data, 2)) else $error("No take.");
    a_temp_source: assert property (
        $changed(temp_o) |-> temp_o == lm0 || temp_o == lm1) else $error("Odd temp.");
    a_oe_rise_time: assert property (
        $rose(sda_oe) |-> !scl_i && ($past(scl_i, 3) || $past(scl_i, 4))) else $error("Late drive.");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_i) else $error("Release high.");
    a_timeout_free: assert property (
        !cfg_o[CFG_TMO_BIT] && low_cnt > TMO_CYCLES + 6 |-> !sda_oe) else $error("No timeout.");
    a_tmo_off_hold: assert property (
        cfg_o[CFG_TMO_BIT] && low_cnt > 8 && $past(sda_oe) |-> sda_oe) else $error("Timed out.");
    a_regs_idle: assert property (
        idle_cnt > 8 |-> $stable({cfg_o, hyst_o, tos_o})) else $error("Write while idle.");
    c_timeout: cover property (!cfg_o[CFG_TMO_BIT] && low_cnt == TMO_CYCLES + 8);
    c_meas_idle: cover property (idle_cnt > 8 && meas_valid);
    c_pec_write: cover property (cfg_o[CFG_PEC_BIT] && $changed(tos_o));
endmodule
bind tsi_slave tsi_slave_sva #(.SLAVE_ADDR(SLAVE_ADDR), .TMO_CYCLES(TMO_CYCLES)) chk_u (
    .sys_clk(sys_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .meas_valid(meas_valid), .meas_data(meas_data), .temp_o(temp_o),
    .cfg_o(cfg_o), .hyst_o(hyst_o), .tos_o(tos_o));

// file: test/tb.sv
// Self-checking bench of the sensor serial slave.
`timescale 1ns/1ns
module tb;
    import tsi_pkg::*;
    typedef struct packed {logic [7:0] ptr; logic [15:0] wr; logic [15:0] exp;} tsi_row_t;
    localparam logic [7:0] AW = {DEF_SLAVE_ADDR, 1'b0};
    localparam logic [7:0] AR = {DEF_SLAVE_ADDR, 1'b1};
    tsi_row_t    rows [5] = '{'{PTR_CFG, 16'h00c0, 16'h00c0}, '{PTR_HYST, 16'h1234, 16'h1234},
        '{PTR_TOS, 16'habcd, 16'habcd}, '{PTR_TEMP, 16'hffff, 16'h0a50}, '{8'h07, 16'h5555, 16'h0}};
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        meas_valid = 1'b0;
    logic [15:0] meas_data = 16'h0;
    logic        scl, sda_lo, sda_oe, sda_o, a;
    logic [15:0] temp_o, cfg_o, hyst_o, tos_o;
    logic [7:0]  tx[$], rx[$], crc, pec_exp;
    int          err_total = 0, n_tests = 0, nak;
    wire         sda = !sda_lo && (sda_oe ? sda_o : 1'b1);
    initial forever #10 sys_clk = ~sys_clk;
    tsi_slave #(.TMO_CYCLES(200)) dut_u (.sys_clk(sys_clk), .rst(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .meas_valid(meas_valid), .meas_data(meas_data),
        .temp_o(temp_o), .cfg_o(cfg_o), .hyst_o(hyst_o), .tos_o(tos_o));
    tsi_bus_master m_u (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
    function automatic logic [7:0] pec8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++)
            x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
        return x;
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic [7:0] b);
        tx.push_back(b);
        crc = pec8(crc, b);
    endtask
    task automatic put(input logic [31:0] w, input int n);
        tx = {};
        crc = 8'h00;
        for (int i = n - 1; i >= 0; i--)
            push(w[8*i +: 8]);
    endtask
    task automatic send();
        nak = 0;
        m_u.start();
        foreach (tx[i]) begin
            m_u.wbyte(tx[i], 0, a);
            if (a !== 1'b1)
                nak++;
        end
        m_u.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        logic [7:0] b;
        rx = {};
        put({AW, ptr, AR}, 3);
        m_u.start();
        m_u.wbyte(AW, 0, a);
        m_u.wbyte(ptr, 0, a);
        m_u.start();
        m_u.wbyte(AR, 0, a);
        for (int i = 0; i < n; i++) begin
            m_u.rbyte(i < n - 1, b);
            pec_exp = crc;
            rx.push_back(b);
            crc = pec8(crc, b);
        end
        m_u.stop();
    endtask
    task automatic meas(input logic [15:0] v);
        @(negedge sys_clk);
        meas_valid = 1'b1;
        meas_data = v;
        @(negedge sys_clk);
        meas_valid = 1'b0;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        m_u.tick(8);
        chk({temp_o, cfg_o, hyst_o, tos_o}, {TEMP_RST, CFG_RST, HYST_RST, TOS_RST});
        meas(16'h0a50);
        m_u.tick(4);
        chk(temp_o, 16'h0a50);
        foreach (rows[i]) begin
            put({AW, rows[i].ptr, rows[i].wr}, 4);
            send();
            chk(nak, 0);
            rd(rows[i].ptr, 2);
            chk({rx[0], rx[1]}, rows[i].exp);
        end
        put({DEF_SLAVE_ADDR + 7'h01, 1'b0}, 1);
        send();
        chk(nak, 1);
        put({AW, PTR_HYST, 16'h1111}, 4);
        push(8'h22);
        push(8'h22);
        send();
        chk(hyst_o, 16'h2222);
        rd(PTR_HYST, 4);
        chk({rx[0], rx[1], rx[2], rx[3]}, 32'h22222222);
        fork
            rd(PTR_TEMP, 2);
            begin
                m_u.tick(300);
                meas(16'h7ff0);
            end
        join
        chk({rx[0], rx[1]}, 16'h0a50);
        m_u.tick(4);
        chk(temp_o, 16'h7ff0);
        m_u.start();
        m_u.wbyte(AW, 300, a);
        chk(a, 1'b0);
        m_u.stop();
        put({AW, PTR_CFG, 16'h00d0}, 4);
        send();
        m_u.start();
        m_u.wbyte(AW, 300, a);
        chk(a, 1'b1);
        m_u.stop();
        put({AW, PTR_CFG, 16'h00d8}, 4);
        send();
        put({AW, PTR_TOS, 16'h1234}, 4);
        push(crc);
        send();
        chk(tos_o, 16'h1234);
        put({AW, PTR_TOS, 16'h5566}, 4);
        send();
        chk(tos_o, 16'h1234);
        tx.push_back(crc ^ 8'h01);
        send();
        chk(tos_o, 16'h1234);
        put({AW, PTR_TOS, 16'h0a0b}, 4);
        push(crc);
        push(8'h0c);
        push(8'h0d);
        push(crc);
        send();
        chk(tos_o, 16'h0c0d);
        rd(PTR_TOS, 3);
        chk({rx[0], rx[1]}, 16'h0c0d);
        chk(rx[2], pec_exp);
        end_of_test();
    end
endmodule
